// ==== design/ees_defines.vh ====
`ifndef EES_DEFINES_VH
`define EES_DEFINES_VH

// ----------------------------------------
// Memory geometry
// ----------------------------------------
`define EES_ADDR_W 11
`define EES_PAGE_W 4
`define EES_BYTE_W 8

// ----------------------------------------
// Slave byte layout
// ----------------------------------------
`define EES_DEV_CODE 4'hA
`define EES_CODE_HI 7
`define EES_CODE_LO 4
`define EES_AHI_HI 3
`define EES_AHI_LO 1
`define EES_DIR_BIT 0
`define EES_BITS_PER_BYTE 4'h8

// ----------------------------------------
// Timing
// ----------------------------------------
`define EES_CLK_KHZ 20000
`define EES_TWR_US 10000
`define EES_TWR_CYCLES ((`EES_TWR_US * `EES_CLK_KHZ) / 1000)

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EES_PTR_RST 11'h000
`define EES_MASK_RST 16'h0000
`define EES_PIN_RST 5'h13

`endif

// ==== design/ees_slave.v ====
// Operation
// - START is falling data with clock high; bus ignored until one is seen.
// - Rising data with clock high is STOP; master ends each operation with STOP.
// - Upper four slave-byte bits must equal 1010 or the device stays silent.
// - Next three slave-byte bits are high memory address bits a8 to a10.
// - Slave-byte bit zero selects direction: one reads, zero writes.
// - Acknowledge pulls data low during ninth clock; done on address match.
// - When selected for write, the address byte is acknowledged; data only with write protect low and buffer not full.
// - Read sends eight bits, samples acknowledge, continues or stops on none.
// - Byte write is slave byte, address, data, STOP; STOP starts programming.
// - While programming, no request is acknowledged, own address included.
// - Page write takes 16 bytes, stepping only the low address bits.
// - More than 16 bytes wrap within the page, overwriting earlier ones.
// - STOP after page write commits all buffered bytes in one cycle.
// - Polling with write slave byte is refused while busy, acknowledged after.
// - Write protect high acks slave and address, refuses first data, programs none.
// - Counter holds last address plus one, wrapping within the page after a write; current read returns that byte.
// - Counter rolls from 2047 to zero and reading continues.
// - Sequential read advances the full counter after every byte.
// - While either reset pin is active the memory side acknowledges nothing.
`include "ees_defines.vh"

module ees_slave #(
  parameter ADDR_W = `EES_ADDR_W,
  parameter PAGE_W = `EES_PAGE_W,
  parameter WR_CYCLES = `EES_TWR_CYCLES
) (
  // Clock and reset
  input wire CLK_SYS,
  input wire RST,
  // Two-wire bus
  input wire SCL_IN,
  input wire SDA_IN,
  output wire SDA_OUT,
  output reg SDA_OE,
  // Protection and supervisor pins
  input wire WP,
  input wire RESET_HI,
  input wire RESET_LO_N,
  // Status
  output reg BUSY
);

  localparam ST_IDLE = 3'h0;
  localparam ST_DEV = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_ACK = 3'h4;
  localparam ST_TX = 3'h5;
  localparam ST_RACK = 3'h6;
  localparam PAGE_N = 1 << PAGE_W;
  localparam MEM_N = 1 << ADDR_W;
  localparam FW = `EES_BYTE_W + PAGE_W;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Full-width step: the read counter wraps from the top address to zero
  function [ADDR_W-1:0] ptr_inc;
    input [ADDR_W-1:0] p;
    begin
      ptr_inc = p + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Low-bit step only: a long page write stays inside its page
  function [PAGE_W-1:0] page_step;
    input [PAGE_W-1:0] lo;
    begin
      page_step = lo + {{(PAGE_W-1){1'b0}}, 1'b1};
    end
  endfunction

  function [PAGE_W-1:0] page_slot;
    input [FW-1:0] entry;
    begin
      page_slot = entry[FW-1:`EES_BYTE_W];
    end
  endfunction

  // Open drain: a one bit is sent by letting go of the line
  function bit_drive;
    input [7:0] b;
    begin
      bit_drive = ~b[7];
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [4:0] pin_m;
  reg [4:0] pin_s;
  reg scl_r;
  reg sda_r;
  wire scl_s = pin_s[0];
  wire sda_s = pin_s[1];
  wire wp_s = pin_s[2];
  wire disabled = pin_s[3] | ~pin_s[4];

  always @(posedge CLK_SYS) begin
    if (RST) begin
      pin_m <= `EES_PIN_RST;
      pin_s <= `EES_PIN_RST;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      pin_m <= {RESET_LO_N, RESET_HI, WP, SDA_IN, SCL_IN};
      pin_s <= pin_m;
      scl_r <= scl_s;
      sda_r <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_r;
  wire scl_fall = ~scl_s & scl_r;
  wire start_det = scl_s & scl_r & sda_r & ~sda_s;
  wire stop_det = scl_s & scl_r & ~sda_r & sda_s;

  // Open drain: only ever pulls low
  assign SDA_OUT = 1'b0;

  // ----------------------------------------
  // Storage and two-entry write buffer
  // ----------------------------------------
  reg [7:0] mem [0:MEM_N-1];
  reg [7:0] page [0:PAGE_N-1];
  reg [PAGE_N-1:0] page_mask;
  reg [ADDR_W-PAGE_W-1:0] page_base;
  reg [FW-1:0] fifo [0:1];
  reg fifo_wp;
  reg fifo_rp;
  reg [1:0] fifo_cnt;
  reg push;
  reg [FW-1:0] push_data;
  reg page_clr;
  reg stop_wr;
  reg commit_req;
  reg [31:0] wr_timer;

  wire fifo_in_ready = (fifo_cnt != 2'h2);
  wire fifo_out_valid = (fifo_cnt != 2'h0);
  // Drain stalls while the array is busy, so the buffer can really fill
  wire fifo_out_ready = ~BUSY;
  wire pop = fifo_out_valid & fifo_out_ready;
  wire [FW-1:0] fifo_head = fifo[fifo_rp];
  integer i;

  always @(posedge CLK_SYS) begin
    if (RST) begin
      fifo_wp <= 1'b0;
      fifo_rp <= 1'b0;
      fifo_cnt <= 2'h0;
    end else begin
      if (push) begin
        fifo[fifo_wp] <= push_data;
        fifo_wp <= ~fifo_wp;
      end
      if (pop) begin
        fifo_rp <= ~fifo_rp;
      end
      fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  always @(posedge CLK_SYS) begin
    if (RST) begin
      page_mask <= `EES_MASK_RST;
      commit_req <= 1'b0;
      BUSY <= 1'b0;
      wr_timer <= 32'h0;
    end else begin
      if (page_clr) begin
        page_mask <= `EES_MASK_RST;
      end else if (pop) begin
        page[page_slot(fifo_head)] <= fifo_head[`EES_BYTE_W-1:0];
        page_mask[page_slot(fifo_head)] <= 1'b1;
      end
      if (stop_wr) begin
        commit_req <= 1'b1;
      end else if (commit_req && !fifo_out_valid) begin
        // Wait until the buffer has drained so no late byte is lost
        commit_req <= 1'b0;
        BUSY <= 1'b1;
        wr_timer <= WR_CYCLES - 1;
        for (i = 0; i < PAGE_N; i = i + 1) begin
          if (page_mask[i]) begin
            mem[{page_base, i[PAGE_W-1:0]}] <= page[i];
          end
        end
      end else if (BUSY) begin
        if (wr_timer == 32'h0) begin
          BUSY <= 1'b0;
        end else begin
          wr_timer <= wr_timer - 32'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Bus engine
  // ----------------------------------------
  reg [2:0] st;
  reg [2:0] ret;
  reg [3:0] cnt;
  reg [7:0] sr;
  reg [ADDR_W-1:0] ptr;
  reg [2:0] addr_hi;
  reg wr_pend;
  reg mack;

  wire dev_match = (sr[`EES_CODE_HI:`EES_CODE_LO] == `EES_DEV_CODE);

  always @(posedge CLK_SYS) begin
    if (RST) begin
      st <= ST_IDLE;
      ret <= ST_IDLE;
      cnt <= 4'h0;
      sr <= 8'h00;
      ptr <= `EES_PTR_RST;
      addr_hi <= 3'h0;
      wr_pend <= 1'b0;
      mack <= 1'b0;
      SDA_OE <= 1'b0;
      push <= 1'b0;
      push_data <= {FW{1'b0}};
      page_clr <= 1'b0;
      stop_wr <= 1'b0;
    end else begin
      push <= 1'b0;
      page_clr <= 1'b0;
      stop_wr <= 1'b0;
      if (disabled) begin
        // Held reset: drop any transfer and stay off the bus
        st <= ST_IDLE;
        SDA_OE <= 1'b0;
        wr_pend <= 1'b0;
      end else if (stop_det) begin
        st <= ST_IDLE;
        SDA_OE <= 1'b0;
        wr_pend <= 1'b0;
        stop_wr <= wr_pend;
      end else if (start_det) begin
        // A repeated start abandons any unfinished write
        st <= ST_DEV;
        cnt <= 4'h0;
        SDA_OE <= 1'b0;
        wr_pend <= 1'b0;
      end else begin
        case (st)
          ST_DEV, ST_ADDR, ST_DATA: begin
            if (scl_rise) begin
              sr <= {sr[6:0], sda_s};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == `EES_BITS_PER_BYTE) begin
              cnt <= 4'h0;
              if (st == ST_DEV) begin
                if (dev_match && !BUSY) begin
                  SDA_OE <= 1'b1;
                  st <= ST_ACK;
                  addr_hi <= sr[`EES_AHI_HI:`EES_AHI_LO];
                  ret <= sr[`EES_DIR_BIT] ? ST_TX : ST_ADDR;
                end else begin
                  st <= ST_IDLE;
                end
              end else if (st == ST_ADDR) begin
                SDA_OE <= 1'b1;
                st <= ST_ACK;
                ret <= ST_DATA;
                ptr <= {addr_hi, sr};
                page_base <= {addr_hi, sr[7:PAGE_W]};
                page_clr <= 1'b1;
              end else if (!wp_s && fifo_in_ready) begin
                SDA_OE <= 1'b1;
                st <= ST_ACK;
                ret <= ST_DATA;
                push <= 1'b1;
                push_data <= {ptr[PAGE_W-1:0], sr};
                ptr[PAGE_W-1:0] <= page_step(ptr[PAGE_W-1:0]);
                wr_pend <= 1'b1;
              end else begin
                // Protected or buffer full: refuse this byte; bytes already accepted still program at STOP
                st <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              st <= ret;
              cnt <= 4'h0;
              if (ret == ST_TX) begin
                sr <= mem[ptr];
                SDA_OE <= bit_drive(mem[ptr]);
                ptr <= ptr_inc(ptr);
              end else begin
                SDA_OE <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              cnt <= cnt + 4'h1;
            end else if (scl_fall) begin
              if (cnt == `EES_BITS_PER_BYTE) begin
                SDA_OE <= 1'b0;
                st <= ST_RACK;
              end else begin
                SDA_OE <= ~sr[6];
                sr <= {sr[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack <= ~sda_s;
            end else if (scl_fall) begin
              cnt <= 4'h0;
              if (mack) begin
                st <= ST_TX;
                sr <= mem[ptr];
                SDA_OE <= bit_drive(mem[ptr]);
                ptr <= ptr_inc(ptr);
              end else begin
                // No acknowledge: wait for the master's stop
                st <= ST_IDLE;
                SDA_OE <= 1'b0;
              end
            end
          end
          default: begin
            st <= ST_IDLE;
            SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // ees_slave

// ==== tb/ees_slave_sva.sv ====
module ees_slave_sva #(
  parameter ADDR_W = 11, PAGE_W = 4, WR_CYCLES = 200000
) (
  // Clock and reset
  input logic CLK_SYS,
  input logic RST,
  // Bus
  input logic SCL_IN,
  input logic SDA_IN,
  input logic SDA_OUT,
  input logic SDA_OE,
  // Pins and status
  input logic WP,
  input logic RESET_HI,
  input logic RESET_LO_N,
  input logic BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic scl_q, sda_q, in_frame;
  int bcnt;
  // ----------------------------------------
  // Frame tracking on the raw wires
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    scl_q <= SCL_IN;
    sda_q <= SDA_IN;
    if (RST) begin
      in_frame <= 1'b0;
      bcnt <= 0;
    end else begin
      if (scl_q && SCL_IN && sda_q != SDA_IN) in_frame <= sda_q;
      bcnt <= BUSY ? bcnt + 1 : 0;
    end
  end
  a_out_zero: assert property (SDA_OUT == 1'b0) else $error("drive value not low");
  a_oe_in_frame: assert property ($rose(SDA_OE) |-> in_frame) else $error("drive before start");
  a_idle_release: assert property (!in_frame [*6] |-> !SDA_OE) else $error("held after stop");
  a_oe_stable_high: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE)) else $error("moved in high");
  a_pin_silent: assert property ((RESET_HI || !RESET_LO_N) [*6] |-> !SDA_OE) else $error("ack in reset");
  a_busy_silent: assert property (BUSY [*6] |-> !SDA_OE) else $error("ack while busy");
  a_busy_after_stop: assert property ($rose(BUSY) |-> SCL_IN && SDA_IN && !in_frame) else $error("busy no stop");
  a_busy_length: assert property ($fell(BUSY) |-> bcnt == WR_CYCLES) else $error("busy length");
endmodule // ees_slave_sva

bind ees_slave ees_slave_sva #(.ADDR_W(ADDR_W), .PAGE_W(PAGE_W), .WR_CYCLES(WR_CYCLES)) ees_slave_sva_inst (
  .CLK_SYS(CLK_SYS), .RST(RST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .WP(WP), .RESET_HI(RESET_HI), .RESET_LO_N(RESET_LO_N), .BUSY(BUSY));

// ==== tb/ees_mst.sv ====
module ees_mst (
  // Clock and wire
  input logic clk,
  input logic sda,
  output logic scl = 1'b1,
  output logic m_oe = 1'b0,
  // Results
  output logic stb = 1'b0,
  output logic [8:0] res = 9'h000
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bit slot of 400 ns, data moves only while clock low
  // ----------------------------------------
  task automatic bit_slot(input logic b, output logic s);
    @(negedge clk);
    m_oe = !b;
    repeat (5) @(negedge clk);
    scl = 1'b1;
    repeat (2) @(negedge clk);
    s = sda;
    scl = 1'b0;
  endtask
  // Long wait lets the device drop its ack first
  task automatic start;
    @(negedge clk);
    m_oe = 1'b0;
    repeat (6) @(negedge clk);
    scl = 1'b1;
    repeat (3) @(negedge clk);
    m_oe = 1'b1;
    repeat (3) @(negedge clk);
    scl = 1'b0;
  endtask
  task automatic stop;
    @(negedge clk);
    m_oe = 1'b1;
    repeat (6) @(negedge clk);
    scl = 1'b1;
    repeat (3) @(negedge clk);
    m_oe = 1'b0;
    repeat (12) @(negedge clk);
  endtask
  task automatic post(input logic [8:0] v);
    res = v;
    stb = 1'b1;
    @(negedge clk);
    stb = 1'b0;
  endtask
  task automatic wb(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], s);
    bit_slot(1'b1, s);
    post({!s, 8'h00});
  endtask
  task automatic rb(input logic ack);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(!ack, s);
    post({1'b0, d});
  endtask
endmodule // ees_mst

// ==== tb/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wp = 1'b0, reset_hi = 1'b0, reset_lo_n = 1'b1;
  logic scl, m_oe, stb, sda_oe, busy;
  logic [8:0] res;
  logic [7:0] pg [16];
  logic [7:0] d0;
  logic [31:0] seed = 32'h4702;
  logic [8:0] q [$];
  int n_mismatch = 0, checks = 0;
  wire sda = !(sda_oe | m_oe);
  always #25 clk = ~clk;
  ees_slave #(.WR_CYCLES(200)) ees_slave_inst (.CLK_SYS(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(), .SDA_OE(sda_oe), .WP(wp), .RESET_HI(reset_hi), .RESET_LO_N(reset_lo_n), .BUSY(busy));
  ees_mst ees_mst_inst (.clk(clk), .sda(sda), .scl(scl), .m_oe(m_oe), .stb(stb), .res(res));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic st; ees_mst_inst.start; endtask
  task automatic sp; ees_mst_inst.stop; endtask
  task automatic wbe(input logic [7:0] d, input logic a);
    q.push_back({a, 8'h00});
    ees_mst_inst.wb(d);
  endtask
  task automatic rbe(input logic [7:0] d, input logic ack);
    q.push_back({1'b0, d});
    ees_mst_inst.rb(ack);
  endtask
  task automatic cmp(input logic [8:0] e, input logic [8:0] s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch result expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_busy(input logic e);
    checks++;
    if (busy !== e) begin
      n_mismatch++;
      $display("mismatch busy expected %b seen %b", e, busy);
    end
  endtask
  always @(posedge clk) begin
    if (stb === 1'b1) cmp(q.pop_front(), res);
  end
  task automatic wait_idle;
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge clk);
    cmp_busy(1'b0);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    n_mismatch++;
    finish_test;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 16; i++) begin
      if (i == 10) continue;
      st;
      wbe({i[3:0], 4'h0}, 1'b0);
      sp;
    end
    $display("test code done");
    seed = xs(seed);
    d0 = seed[7:0];
    st;
    wbe(8'hA0, 1'b1);
    wbe(8'h00, 1'b1);
    wbe(d0, 1'b1);
    sp;
    cmp_busy(1'b1);
    st;
    wbe(8'hA0, 1'b0);
    sp;
    wait_idle;
    st;
    wbe(8'hA0, 1'b1);
    sp;
    $display("test byte write done");
    st;
    wbe(8'hAE, 1'b1);
    wbe(8'hF2, 1'b1);
    for (int k = 0; k < 18; k++) begin
      seed = xs(seed);
      pg[(k + 2) % 16] = seed[7:0];
      wbe(seed[7:0], 1'b1);
    end
    sp;
    cmp_busy(1'b1);
    wait_idle;
    st;
    wbe(8'hAE, 1'b1);
    wbe(8'hF0, 1'b1);
    st;
    wbe(8'hA1, 1'b1);
    rbe(pg[0], 1'b0);
    sp;
    st;
    wbe(8'hA1, 1'b1);
    for (int k = 1; k < 16; k++) rbe(pg[k], 1'b1);
    rbe(d0, 1'b0);
    sp;
    $display("test page and reads done");
    wp = 1'b1;
    st;
    wbe(8'hA0, 1'b1);
    wbe(8'h00, 1'b1);
    wbe(~d0, 1'b0);
    sp;
    wp = 1'b0;
    cmp_busy(1'b0);
    st;
    wbe(8'hA0, 1'b1);
    wbe(8'h00, 1'b1);
    st;
    wbe(8'hA1, 1'b1);
    rbe(d0, 1'b0);
    sp;
    $display("test protect done");
    for (int p = 0; p < 2; p++) begin
      reset_hi = (p == 0);
      reset_lo_n = (p == 0);
      repeat (8) @(negedge clk);
      st;
      wbe(8'hA1, 1'b0);
      sp;
    end
    reset_hi = 1'b0;
    reset_lo_n = 1'b1;
    repeat (4) @(negedge clk);
    st;
    wbe(8'hA0, 1'b1);
    sp;
    $display("test reset pins done");
    repeat (4) @(negedge clk);
    finish_test;
  end
endmodule // tb_top
